// >>> timer3_map.svh
`ifndef TIMER3_MAP_SVH
`define TIMER3_MAP_SVH
// ****************************************
// special function register map
// ****************************************
`define TIMER3_CTRL_ADDR 8'h91
`define TIMER3_CTRL_RESET 8'h00
`define TIMER3_UNUSED_MASK 8'hfd
// ****************************************
// field positions of the control register
// ****************************************
`define TIMER3_HI_FLAG_BIT 7
`define TIMER3_LO_FLAG_BIT 6
`define TIMER3_LO_IRQ_EN_BIT 5
`define TIMER3_CAPTURE_BIT 4
`define TIMER3_SPLIT_BIT 3
`define TIMER3_RUN_BIT 2
`define TIMER3_UNUSED_BIT 1
`define TIMER3_XCLK_BIT 0
// ****************************************
// timing counts
// ****************************************
`define TIMER3_SYS_DIV_LAST 4'hb
`define TIMER3_EXT_DIV_LAST 3'h7
`define TIMER3_BYTE_MAX 8'hff
`define TIMER3_WORD_MAX 16'hffff
`endif

// >>> timer3_pkg.sv
`default_nettype none
package timer3_pkg;
	// one special function register write or read cycle
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
	} sfr_req_t;
	// control register image, msb first
	typedef struct packed {
		logic high_byte_overflow_flag;
		logic low_byte_overflow_flag;
		logic low_byte_irq_enable;
		logic capture_mode_enable;
		logic split_mode_select;
		logic run_control_bit;
		logic unused;
		logic external_clock_select;
	} timer_three_control_reg_t;
endpackage
`default_nettype wire

// >>> timer3_control_logic.sv
// Notes on behaviour
// R1: high byte rolling 0xFF to 0x00 sets the high-byte overflow flag.
// R2: in 16-bit mode high flag sets only on full 0xFFFF to 0x0000 rollover.
// R3: with timer interrupt enabled, request stands while high flag is set.
// R4: flags never clear themselves; only a software write of zero clears.
// R5: low byte rolling 0xFF to 0x00 sets low flag in every mode.
// R6: low irq enable plus timer enable requests interrupt on low overflow.
// R7: capture-mode enable bit, 1 active, 0 disabled.
// R8: split bit 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// R9: counting only while run bit is 1; in 16-bit it gates everything.
// R10: in split mode run gates only high byte; low byte always runs.
// R11: unused bit 1 reads zero and ignores writes.
// R12: clock select 0 clocks timer from system clock divided by 12.
// R13: clock select 1 uses external clock divided by 8, synchronised.
// R14: in split mode clock select picks external source for both bytes.
// R15: per-byte clock select inputs pick system clock independently per byte.
// R16: each overflow reloads the affected counter from its reload value; in 16-bit mode a low-byte overflow short of 0xFFFF only carries, no reload.
`include "timer3_map.svh"
`timescale 1ns/1ps
`default_nettype none

module timer3_control_logic
	import timer3_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_resetn,
	input wire sfr_req_t i_sfr,
	input wire logic i_timer_irq_enable,
	input wire logic i_high_byte_clock_select,
	input wire logic i_low_byte_clock_select,
	input wire logic i_ext_clock,
	input wire logic [15:0] i_reload_value,
	output logic [7:0] o_sfr_rdata,
	output logic [15:0] o_count,
	output logic o_irq,
	output logic o_capture_mode_enable
);

	// ****************************************
	// declarations
	// ****************************************
	timer_three_control_reg_t ctrl_ff;
	timer_three_control_reg_t nxt_ctrl;
	logic [7:0] rdata_ff;
	logic [15:0] count_ff;
	logic [15:0] nxt_count;
	logic irq_ff;
	logic nxt_irq;
	logic [3:0] sys_div_ff;
	logic [2:0] ext_div_ff;
	logic ext_sync1_ff;
	logic ext_sync2_ff;
	logic ext_sync3_ff;
	logic ext_level_ff;
	logic ctrl_wr;
	logic sys_tick;
	logic ext_rise;
	logic ext_tick;
	logic lo_tick;
	logic hi_tick;
	logic lo_step;
	logic hi_step;
	logic lo_ovf;
	logic hi_ovf;

	// byte tick: direct system clock, else divided source chosen by xclk
	function automatic logic byte_tick(input logic sel_sys, input logic xclk,
		input logic t_sys, input logic t_ext);
		byte_tick = sel_sys ? 1'b1 : (xclk ? t_ext : t_sys);
	endfunction

	// ****************************************
	// register access
	// ****************************************
	assign ctrl_wr = i_sfr.wr && (i_sfr.addr == `TIMER3_CTRL_ADDR);

	// software image first, hardware sets on top so a set beats a clear
	always_comb begin
		nxt_ctrl = ctrl_ff;
		if (ctrl_wr) begin
			nxt_ctrl = timer_three_control_reg_t'(i_sfr.wdata & `TIMER3_UNUSED_MASK); // see R11
		end
		nxt_ctrl.unused = 1'b0; // see R11
		if (hi_ovf) begin
			nxt_ctrl.high_byte_overflow_flag = 1'b1; // see R1 see R4
		end
		if (lo_ovf) begin
			nxt_ctrl.low_byte_overflow_flag = 1'b1; // see R5 see R4
		end
	end

	// control register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_ff <= timer_three_control_reg_t'(`TIMER3_CTRL_RESET);
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	// read data is registered, so it trails the register by one cycle
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			rdata_ff <= `TIMER3_CTRL_RESET;
		end else begin
			rdata_ff <= ctrl_ff & `TIMER3_UNUSED_MASK; // see R11
		end
	end

	// ****************************************
	// clock sources
	// ****************************************
	// system clock prescaler, free running so ticks are evenly spaced
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			sys_div_ff <= 4'h0;
		end else if (sys_div_ff == `TIMER3_SYS_DIV_LAST) begin
			sys_div_ff <= 4'h0;
		end else begin
			sys_div_ff <= sys_div_ff + 4'h1;
		end
	end

	assign sys_tick = (sys_div_ff == `TIMER3_SYS_DIV_LAST); // see R12

	// external clock synchroniser, first stage feeds only the second
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ext_sync1_ff <= 1'b0;
			ext_sync2_ff <= 1'b0;
			ext_sync3_ff <= 1'b0;
		end else begin
			ext_sync1_ff <= i_ext_clock;
			ext_sync2_ff <= ext_sync1_ff;
			ext_sync3_ff <= ext_sync2_ff;
		end
	end

	// settled pin level, moved only when stages two and three agree
	// resets low like the idle pin, so no false rise follows reset
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ext_level_ff <= 1'b0;
		end else if (ext_sync2_ff == ext_sync3_ff) begin
			ext_level_ff <= ext_sync3_ff;
		end
	end

	// a rise counts once stages two and three agree on the new level
	assign ext_rise = ext_sync2_ff && ext_sync3_ff && !ext_level_ff;

	// divide by eight; external clock must stay at or below a quarter of the system rate
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			ext_div_ff <= 3'h0;
		end else if (ext_rise) begin
			ext_div_ff <= ext_div_ff + 3'h1;
		end
	end

	assign ext_tick = ext_rise && (ext_div_ff == `TIMER3_EXT_DIV_LAST); // see R13

	// one xclk bit serves both bytes, per-byte selects override it
	assign lo_tick = byte_tick(i_low_byte_clock_select, ctrl_ff.external_clock_select,
		sys_tick, ext_tick); // see R14 see R15
	assign hi_tick = byte_tick(i_high_byte_clock_select, ctrl_ff.external_clock_select,
		sys_tick, ext_tick); // see R14 see R15

	// ****************************************
	// counter
	// ****************************************
	// 16-bit mode runs on the low byte's clock under the run bit
	always_comb begin
		if (ctrl_ff.split_mode_select) begin
			lo_step = lo_tick; // see R10
			hi_step = hi_tick && ctrl_ff.run_control_bit; // see R10
		end else begin
			lo_step = lo_tick && ctrl_ff.run_control_bit; // see R9
			hi_step = 1'b0;
		end
	end

	// overflow events feed the flags
	always_comb begin
		lo_ovf = lo_step && (count_ff[7:0] == `TIMER3_BYTE_MAX); // see R5
		if (ctrl_ff.split_mode_select) begin
			hi_ovf = hi_step && (count_ff[15:8] == `TIMER3_BYTE_MAX); // see R1
		end else begin
			hi_ovf = lo_step && (count_ff == `TIMER3_WORD_MAX); // see R2
		end
	end

	// next count with auto reload
	always_comb begin
		nxt_count = count_ff;
		if (ctrl_ff.split_mode_select) begin // see R8
			if (lo_step) begin
				nxt_count[7:0] = (count_ff[7:0] == `TIMER3_BYTE_MAX) ?
					i_reload_value[7:0] : count_ff[7:0] + 8'h01; // see R16
			end
			if (hi_step) begin
				nxt_count[15:8] = (count_ff[15:8] == `TIMER3_BYTE_MAX) ?
					i_reload_value[15:8] : count_ff[15:8] + 8'h01; // see R16
			end
		end else if (lo_step) begin
			nxt_count = (count_ff == `TIMER3_WORD_MAX) ?
				i_reload_value : count_ff + 16'h0001; // see R16 see R8
		end
	end

	// count register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			count_ff <= 16'h0000;
		end else begin
			count_ff <= nxt_count;
		end
	end

	// ****************************************
	// interrupt request
	// ****************************************
	// level request, held as long as an enabled flag stays set
	assign nxt_irq = i_timer_irq_enable && (nxt_ctrl.high_byte_overflow_flag ||
		(nxt_ctrl.low_byte_overflow_flag && nxt_ctrl.low_byte_irq_enable)); // see R3 see R6

	// request register
	always_ff @(posedge i_clock or negedge i_resetn) begin
		if (!i_resetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
		end
	end

	// outputs straight from flops
	assign o_sfr_rdata = rdata_ff;
	assign o_count = count_ff;
	assign o_irq = irq_ff;
	assign o_capture_mode_enable = ctrl_ff.capture_mode_enable; // see R7

	// ****************************************
	// assertions
	// ****************************************
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_resetn);

	sequence full_wrap_s;
		!ctrl_ff.split_mode_select && lo_step && (count_ff == `TIMER3_WORD_MAX);
	endsequence

	// settled rise of the external pin
	sequence ext_edge_s;
		ext_sync2_ff && ext_sync3_ff && !ext_level_ff;
	endsequence

	hi_flag_set_a: assert property (hi_ovf |=> ctrl_ff.high_byte_overflow_flag) // see R1
		else $error("high flag not set after high overflow");
	full_wrap_a: assert property (full_wrap_s |=> // see R2
		ctrl_ff.high_byte_overflow_flag && count_ff == $past(i_reload_value))
		else $error("16-bit wrap did not set flag and reload");
	hi_only_full_a: assert property (!ctrl_ff.split_mode_select && lo_step && // see R2
		count_ff[15:8] == 8'hff && count_ff[7:0] != 8'hff |-> !hi_ovf)
		else $error("high flag event before full wrap");
	// a clearing write in the same cycle legally drops the request
	irq_hi_a: assert property (i_timer_irq_enable && !ctrl_wr && // see R3
		ctrl_ff.high_byte_overflow_flag |=> o_irq)
		else $error("no request with high flag set");
	flag_hold_a: assert property (ctrl_ff.high_byte_overflow_flag && !ctrl_wr |=> // see R4
		ctrl_ff.high_byte_overflow_flag)
		else $error("high flag cleared without a write");
	lo_flag_set_a: assert property (lo_ovf |=> ctrl_ff.low_byte_overflow_flag) // see R5
		else $error("low flag not set after low overflow");
	irq_lo_a: assert property (lo_ovf && i_timer_irq_enable && // see R6
		ctrl_ff.low_byte_irq_enable && !ctrl_wr |=> o_irq)
		else $error("no request after enabled low overflow");
	// back to back writes are legal, so look one edge after each write
	capture_bit_a: assert property (ctrl_wr |=> o_capture_mode_enable == // see R7
		$past(i_sfr.wdata[`TIMER3_CAPTURE_BIT]))
		else $error("capture enable does not follow write");
	stopped_hold_a: assert property (!ctrl_ff.split_mode_select && // see R9
		!ctrl_ff.run_control_bit |=> $stable(count_ff))
		else $error("16-bit counter moved while stopped");
	split_low_runs_a: assert property (ctrl_ff.split_mode_select && lo_tick && // see R10
		count_ff[7:0] != 8'hff |=> count_ff[7:0] == $past(count_ff[7:0]) + 8'h01)
		else $error("split low byte did not advance");
	high_held_a: assert property (ctrl_ff.split_mode_select && // see R10
		!ctrl_ff.run_control_bit |=> count_ff[15:8] == $past(count_ff[15:8]))
		else $error("split high byte moved while stopped");
	unused_zero_a: assert property (o_sfr_rdata[`TIMER3_UNUSED_BIT] == 1'b0) // see R11
		else $error("unused bit reads one");
	sys_div_a: assert property (sys_tick |=> !sys_tick ##11 sys_tick) // see R12
		else $error("system prescaler period is not twelve");
	// successive ticks are eight settled rises, so at least thirty-two cycles, apart
	ext_div_a: assert property (ext_tick |-> ext_edge_s ##1 !ext_tick [*8]) // see R13
		else $error("external tick not on a settled rise or too soon");
	hi_fast_a: assert property (ctrl_ff.split_mode_select && // see R15
		ctrl_ff.run_control_bit && i_high_byte_clock_select &&
		count_ff[15:8] != 8'hff |=> count_ff[15:8] == $past(count_ff[15:8]) + 8'h01)
		else $error("high byte select did not step every cycle");
	split_reload_a: assert property (ctrl_ff.split_mode_select && lo_step && // see R16
		count_ff[7:0] == 8'hff |=> count_ff[7:0] == $past(i_reload_value[7:0]))
		else $error("split low byte did not reload");
endmodule // timer3_control_logic

`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import timer3_pkg::*;
	// ****************************************
	// stimulus and observed signals
	// ****************************************
	logic i_clock, i_resetn, i_ext_clock, hi_sel, lo_sel, irq_en, ext_on, irq, cap;
	sfr_req_t sfr;
	logic [15:0] reload, cnt, rdw;
	logic [7:0] rd;
	int n_fail, n_compared, cyc, ph;
	assign rdw = {8'h00, rd};

	timer3_control_logic i_timer3_control_logic (
		.i_clock(i_clock),
		.i_resetn(i_resetn),
		.i_sfr(sfr),
		.i_timer_irq_enable(irq_en),
		.i_high_byte_clock_select(hi_sel),
		.i_low_byte_clock_select(lo_sel),
		.i_ext_clock(i_ext_clock),
		.i_reload_value(reload),
		.o_sfr_rdata(rd),
		.o_count(cnt),
		.o_irq(irq),
		.o_capture_mode_enable(cap)
	);

	// 40 MHz system clock
	initial begin
		i_clock = 1'b0;
		forever #12.5 i_clock = ~i_clock;
	end

	// hang guard: the full 16-bit climb alone takes about 65k cycles
	always @(posedge i_clock) begin
		cyc++;
		if (cyc == 80000) begin
			n_fail++;
			report_and_stop();
		end
	end

	// external pin toggles every two cycles, so one rise per four cycles
	// it rests low while unused, so only this process drives it
	always @(negedge i_clock) begin
		ph <= ph + 1;
		if (!ext_on)
			i_ext_clock <= 1'b0;
		else if (ph[0])
			i_ext_clock <= ~i_ext_clock;
	end

	// ****************************************
	// shared tasks
	// ****************************************
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task cy(input int n);
		repeat (n) @(negedge i_clock);
	endtask

	// rdata lags the register by one edge, so wait two edges in all
	task wr(input logic [7:0] d);
		sfr <= '{8'h91, d, 1'b1};
		cy(1);
		sfr.wr <= 1'b0;
		cy(1);
	endtask

	// cycles between two successive count steps
	task gap(output logic [15:0] n);
		logic [15:0] c;
		int k;
		c = cnt;
		k = 0;
		while (cnt === c && k < 200) begin
			cy(1);
			k++;
		end
		c = cnt;
		n = 0;
		while (cnt === c && n < 200) begin
			cy(1);
			n++;
		end
	endtask

	task report_and_stop;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	task t_reg;
		chk("ctrl reset", rdw, 16'h0000);
		wr(8'hff);
		chk("unused bit", rdw, 16'h00fd);
		chk("capture on", {15'h0000, cap}, 16'h0001);
		chk("irq on flag", {15'h0000, irq}, 16'h0001);
		wr(8'h00);
		chk("flags clear", rdw, 16'h0000);
		chk("capture off", {15'h0000, cap}, 16'h0000);
		chk("no count", cnt, 16'h0000);
	endtask

	task t_clk;
		logic [15:0] n;
		wr(8'h04);
		gap(n);
		chk("sys div", n, 16'd12);
		ext_on = 1'b1;
		wr(8'h05);
		gap(n);
		chk("ext div", n, 16'd32);
		lo_sel <= 1'b1;
		cy(2);
		gap(n);
		chk("byte select", n, 16'd1);
		lo_sel <= 1'b0;
	endtask

	task t_split;
		logic [15:0] n;
		logic [7:0] h;
		int k;
		wr(8'h09);
		h = cnt[15:8];
		gap(n);
		chk("split ext", n, 16'd32);
		chk("high held", {8'h00, cnt[15:8]}, {8'h00, h});
		ext_on = 1'b0;
		lo_sel <= 1'b1;
		wr(8'h28);
		for (k = 0; k < 300 && rd[6] !== 1'b1; k++)
			cy(1);
		chk("low flag split", {15'h0000, rd[6]}, 16'h0001);
		chk("low irq", {15'h0000, irq}, 16'h0001);
		chk("no hi flag", {15'h0000, rd[7]}, 16'h0000);
		chk("high still", {8'h00, cnt[15:8]}, {8'h00, h});
		wr(8'h08);
		for (k = 0; k < 300 && rd[6] !== 1'b1; k++)
			cy(1);
		chk("low flag again", {15'h0000, rd[6]}, 16'h0001);
		chk("low irq off", {15'h0000, irq}, 16'h0000);
		hi_sel <= 1'b1;
		lo_sel <= 1'b0;
		wr(8'h0c);
		for (k = 0; k < 400 && rd[7] !== 1'b1; k++)
			cy(1);
		chk("split high flag", {15'h0000, rd[7]}, 16'h0001);
		chk("irq split high", {15'h0000, irq}, 16'h0001);
		wr(8'h08);
	endtask

	task t_wide;
		logic [15:0] n;
		int k;
		lo_sel <= 1'b1;
		reload <= 16'hfffe;
		wr(8'h04);
		for (k = 0; k < 600 && !(cnt[7:0] === 8'hff && cnt[15:8] !== 8'hff); k++)
			cy(1);
		cy(2);
		chk("low wrap only", rdw & 16'h00c0, 16'h0040);
		for (k = 0; k < 70000 && cnt !== 16'hffff; k++)
			cy(1);
		cy(1);
		chk("reload", cnt, 16'hfffe);
		cy(1);
		chk("both flags", rdw & 16'h00c0, 16'h00c0);
		chk("irq high", {15'h0000, irq}, 16'h0001);
		wr(8'hc0);
		n = cnt;
		cy(5);
		chk("stopped", cnt, n);
		chk("flags kept", rdw, 16'h00c0);
		wr(8'h00);
		chk("irq gone", {15'h0000, irq}, 16'h0000);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		i_resetn = 1'b0;
		sfr = '{8'h00, 8'h00, 1'b0};
		hi_sel = 1'b0;
		lo_sel = 1'b0;
		irq_en = 1'b1;
		ext_on = 1'b0;
		reload = 16'h0000;
		cy(10);
		i_resetn <= 1'b1;
		cy(1);
		t_reg();
		t_clk();
		t_split();
		t_wide();
		report_and_stop();
	end
endmodule // tb
`default_nettype wire
